// ---- hdl/ddrwl_top.sv ----
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - level_enable_bit enters and leaves leveling mode
// - Leveling: term_ctl switches strobe termination only
// - Data lines undefined until leveling feedback
// - Strobe rise samples clock, fed back on data
// - Activate opens row in selected bank
// - Precharge closes rows, ready after row_close_time
// - Other-bank access allowed during auto precharge
// - Precharge to idle bank restarts its period
// - burst_select_line picks chopped or full burst
// - Full burst on the fly needs fixed/otf field
module ddrwl_top
   import ddrwl_pkg::*;
#(
   parameter int NBANK = 8
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ck_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic [2:0]  ba_i,
   input  wire logic [14:0] addr_i,
   input  wire logic        term_ctl_i,
   input  wire logic        strobe_i,
   output logic      [7:0]  dq_o,
   output logic             dq_oe_o,
   output logic             dq_undef_o,
   output logic             strobe_term_o,
   output logic             dq_term_o,
   output logic             rd_start_o,
   output logic             rd_chop_o,
   output logic             rd_active_o
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   ddrwl_cmd_t pin_q1, pin_q2;
   logic       ck_q1, ck_q2, ck_q3;
   logic       stb_q1, stb_q2, stb_q3;

   // Two flops on every pin; ck and strobe get a third flop whose output also feeds the edge detectors
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q1 <= '0;
         pin_q2 <= '0;
         ck_q1  <= 1'b0;
         ck_q2  <= 1'b0;
         ck_q3  <= 1'b0;
         stb_q1 <= 1'b0;
         stb_q2 <= 1'b0;
         stb_q3 <= 1'b0;
      end else begin
         pin_q1 <= '{cmd: {cs_n_i, ras_n_i, cas_n_i, we_n_i},
                     ba: ba_i, addr: addr_i, term: term_ctl_i};
         pin_q2 <= pin_q1;
         ck_q1  <= ck_i;
         ck_q2  <= ck_q1;
         ck_q3  <= ck_q2;
         stb_q1 <= strobe_i;
         stb_q2 <= stb_q1;
         stb_q3 <= stb_q2;
      end
   end

   logic ck_rise;
   logic stb_rise;
   logic [3:0] cmd;
   logic [2:0] bank;
   assign ck_rise  = ck_q2 & ~ck_q3;
   assign stb_rise = stb_q2 & ~stb_q3;
   // Deselect folds into no-operation
   assign cmd      = pin_q2.cmd[3] ? CMD_NOP : pin_q2.cmd;
   assign bank     = pin_q2.ba;

   // ---------------------------------------------------------------
   // Mode registers and leveling state
   // ---------------------------------------------------------------
   logic [14:0] primary_mode_reg_q;
   logic [14:0] aux_mode_reg_q;
   logic        level_q;
   logic        is_mrs;
   assign is_mrs = ck_rise && cmd == CMD_MRS;

   // Mode register set writes the register the bank lines pick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         primary_mode_reg_q <= '0;
         aux_mode_reg_q     <= '0;
         level_q            <= 1'b0;
      end else if (is_mrs) begin
         if (bank == MR_PRIMARY)
            primary_mode_reg_q <= pin_q2.addr;
         if (bank == MR_AUX) begin
            aux_mode_reg_q <= pin_q2.addr;
            level_q        <= pin_q2.addr[LEVEL_EN_POS];
         end
      end
   end

   // Termination: leveling keeps data lines unterminated
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_term_o <= 1'b0;
         dq_term_o     <= 1'b0;
      end else if (ck_rise) begin
         strobe_term_o <= pin_q2.term;
         dq_term_o     <= level_q ? 1'b0 : pin_q2.term;
      end
   end

   // ---------------------------------------------------------------
   // Leveling feedback
   // ---------------------------------------------------------------
   logic [7:0] fb_cnt_q;
   logic       fb_val_q;
   logic       fb_live_q;
   logic       fb_out_q;
   logic [7:0] mod_cnt_q;
   logic       exit_mrs;
   assign exit_mrs = is_mrs && bank == MR_AUX && level_q &&
                     !pin_q2.addr[LEVEL_EN_POS];

   // Strobe rise latches the clock level, then waits feedback_delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fb_cnt_q  <= '0;
         fb_val_q  <= 1'b0;
         fb_live_q <= 1'b0;
         fb_out_q  <= 1'b0;
      end else if (!level_q || exit_mrs) begin
         fb_cnt_q  <= '0;
         fb_live_q <= 1'b0;
      end else if (stb_rise) begin
         fb_val_q <= ck_q2;
         fb_cnt_q <= 8'(FB_DELAY_CYC);
      end else if (fb_cnt_q != '0) begin
         fb_cnt_q <= fb_cnt_q - 8'h01;
         if (fb_cnt_q == 8'h01) begin
            fb_live_q <= 1'b1;
            fb_out_q  <= fb_val_q;
         end
      end
   end

   // Exit holds data undefined for mode_update_delay clocks
   always_ff @(posedge clk_i) begin
      if (rst_i)
         mod_cnt_q <= '0;
      else if (exit_mrs)
         mod_cnt_q <= 8'(MOD_DELAY_CK);
      else if (ck_rise && mod_cnt_q != '0)
         mod_cnt_q <= mod_cnt_q - 8'h01;
   end

   // Data pins: feedback on all bits, no read strobe needed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dq_o       <= '0;
         dq_oe_o    <= 1'b0;
         dq_undef_o <= 1'b0;
      end else begin
         dq_o       <= {8{fb_out_q}};
         dq_oe_o    <= level_q && fb_live_q &&
                       !aux_mode_reg_q[OUT_OFF_POS];
         dq_undef_o <= (level_q && !fb_live_q) ||
                       mod_cnt_q != '0;
      end
   end

   // ---------------------------------------------------------------
   // Bank state
   // ---------------------------------------------------------------
   logic [NBANK-1:0] open_q;
   logic [14:0]      row_q [NBANK];
   logic [7:0]       rp_cnt_q [NBANK];
   logic [7:0]       trp_q;
   logic             is_col;
   logic             auto_pre;
   assign is_col   = ck_rise && (cmd == CMD_RD || cmd == CMD_WR);
   assign auto_pre = is_col && pin_q2.addr[AUTO_PRE_POS] &&
                     open_q[bank];

   // Bank may be activated once idle and its period expired
   function automatic logic bank_ready(input logic [7:0] cnt,
                                       input logic       is_open);
      bank_ready = !is_open && cnt == 8'h00;
   endfunction

   logic act_ok;
   assign act_ok = ck_rise && cmd == CMD_ACT && !level_q &&
                   bank_ready(rp_cnt_q[bank], open_q[bank]);

   // Open and close rows, run precharge periods per bank
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         open_q <= '0;
         for (int i = 0; i < NBANK; i++) begin
            row_q[i]    <= '0;
            rp_cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NBANK; i++) begin
            if (ck_rise && rp_cnt_q[i] != '0)
               rp_cnt_q[i] <= rp_cnt_q[i] - 8'h01;
            // Precharge to one or all banks; restarts the period
            if (ck_rise && cmd == CMD_PRE && !level_q &&
                (pin_q2.addr[AUTO_PRE_POS] || bank == 3'(i))) begin
               open_q[i]   <= 1'b0;
               rp_cnt_q[i] <= trp_q;
            end
            // Auto precharge only touches its own bank
            if (auto_pre && bank == 3'(i)) begin
               open_q[i]   <= 1'b0;
               rp_cnt_q[i] <= trp_q;
            end
            if (act_ok && bank == 3'(i)) begin
               open_q[i] <= 1'b1;
               row_q[i]  <= pin_q2.addr;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read burst timing
   // ---------------------------------------------------------------
   logic [3:0] al_q;
   logic [3:0] cl_q;
   logic [5:0] rl_cnt_q;
   logic [3:0] beat_cnt_q;
   logic       chop_pend_q;
   logic       col_chop;
   logic       rd_ok;
   logic       cmd_err_q;

   // Chop unless full burst chosen on the fly in fixed/otf field
   assign col_chop = !(pin_q2.addr[BURST_SEL] &&
                       (primary_mode_reg_q[1:0] == BL_FIXED8 ||
                        primary_mode_reg_q[1:0] == BL_OTF));
   // Reads to other banks pass during auto precharge
   assign rd_ok = is_col && cmd == CMD_RD && open_q[bank] &&
                  !level_q;

   // Latency countdown then burst window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rl_cnt_q    <= '0;
         beat_cnt_q  <= '0;
         chop_pend_q <= 1'b0;
         rd_start_o  <= 1'b0;
         rd_chop_o   <= 1'b0;
         rd_active_o <= 1'b0;
      end else begin
         rd_start_o <= 1'b0;
         if (rd_ok) begin
            rl_cnt_q    <= 6'(al_q) + 6'(cl_q);
            chop_pend_q <= col_chop;
         end else if (ck_rise && rl_cnt_q != '0) begin
            rl_cnt_q <= rl_cnt_q - 6'h01;
            if (rl_cnt_q == 6'h01) begin
               rd_start_o  <= 1'b1;
               rd_chop_o   <= chop_pend_q;
               rd_active_o <= 1'b1;
               beat_cnt_q  <= chop_pend_q ? 4'(BURST_CK_CHOP)
                                          : 4'(BURST_CK_FULL);
            end
         end else if (ck_rise && beat_cnt_q != '0) begin
            beat_cnt_q <= beat_cnt_q - 4'h1;
            if (beat_cnt_q == 4'h1)
               rd_active_o <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register bus slave
   // ---------------------------------------------------------------
   logic wb_req;
   logic wb_wr;
   logic bad_cmd;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr  = wb_req && wb_we_i;

   // Misuse seen on the link: flags it rather than acting on it, except that auto precharge during leveling still closes its bank
   assign bad_cmd = ck_rise && (
      (level_q && cmd != CMD_NOP && cmd != CMD_MRS) ||
      (cmd == CMD_ACT && !level_q && !act_ok) ||
      (is_col && !open_q[bank]));

   // Latency and precharge period are software settings
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         al_q  <= LAT_AL_RST;
         cl_q  <= LAT_CL_RST;
         trp_q <= TRP_RST;
      end else if (wb_wr) begin
         if (wb_adr_i == REG_LAT && wb_sel_i[0]) begin
            al_q <= wb_dat_i[3:0];
            cl_q <= wb_dat_i[7:4];
         end
         if (wb_adr_i == REG_TRP && wb_sel_i[0])
            trp_q <= wb_dat_i[7:0];
      end
   end

   // Sticky error; a new error wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i)
         cmd_err_q <= 1'b0;
      else if (bad_cmd)
         cmd_err_q <= 1'b1;
      else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] &&
               wb_dat_i[0])
         cmd_err_q <= 1'b0;
   end

   // One-cycle ack, registered read data; unmapped reads as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= '0;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               REG_STATUS: wb_dat_o <= {16'h0000, open_q,
                                        4'h0, dq_undef_o,
                                        strobe_term_o, level_q,
                                        cmd_err_q};
               REG_LAT:    wb_dat_o <= {24'h000000, cl_q, al_q};
               REG_TRP:    wb_dat_o <= {24'h000000, trp_q};
               REG_MODE:   wb_dat_o <= {1'b0, aux_mode_reg_q,
                                        1'b0, primary_mode_reg_q};
               default:    wb_dat_o <= '0;
            endcase
         end
      end
   end

endmodule

// ---- hdl/ddrwl_pkg.sv ----
package ddrwl_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 4000;   // 250 MHz core clock
   localparam int FB_DELAY_NS    = 8;      // feedback_delay, longest
   localparam int FB_DELAY_CYC   = (FB_DELAY_NS * 1000 / CLK_PERIOD_PS)
                                   < 1 ? 1 :
                                   (FB_DELAY_NS * 1000 / CLK_PERIOD_PS);
   localparam int MOD_DELAY_CK   = 12;     // mode_update_delay, link clocks
   localparam int MRD_GAP_CK     = 4;      // mode_cmd_gap, link clocks
   localparam int BURST_CK_FULL  = 4;      // eight beats, two per clock
   localparam int BURST_CK_CHOP  = 2;      // four beats

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_LAT    = 8'h04;
   localparam logic [7:0] REG_TRP    = 8'h08;
   localparam logic [7:0] REG_MODE   = 8'h0C;
   localparam logic [3:0] LAT_AL_RST = 4'h0;
   localparam logic [3:0] LAT_CL_RST = 4'h5;
   localparam logic [7:0] TRP_RST    = 8'h0B;

   // ---------------------------------------------------------------
   // Mode register fields
   // ---------------------------------------------------------------
   localparam logic [2:0] MR_PRIMARY = 3'h0;
   localparam logic [2:0] MR_AUX     = 3'h1;
   localparam int LEVEL_EN_POS = 7;        // level_enable_bit
   localparam int OUT_OFF_POS  = 12;       // output_off_bit
   localparam int BURST_SEL    = 12;       // burst_select_line
   localparam int AUTO_PRE_POS = 10;       // auto / all-bank precharge
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;

   // ---------------------------------------------------------------
   // Commands {cs_n, ras_n, cas_n, we_n}
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_MRS = 4'h0;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [2:0]  ba;
      logic [14:0] addr;
      logic        term;
   } ddrwl_cmd_t;

endpackage

// ---- verif/ddrwl_top_asserts.sv ----
`timescale 1ns/1ps
// --------
// Port checks
// --------
module ddrwl_top_asserts (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic [7:0] dq_o,
   input wire logic       dq_oe_o,
   input wire logic       dq_undef_o,
   input wire logic       dq_term_o,
   input wire logic       rd_start_o,
   input wire logic       rd_chop_o,
   input wire logic       rd_active_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [7:0] len_q;
   // Burst window length; ck jitter on the sync allows two cycles slack
   always_ff @(posedge clk_i) begin
      if (rst_i || !rd_active_o) begin
         len_q <= 8'h00;
      end else begin
         len_q <= len_q + 8'h01;
      end
   end
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acked");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dq_term_off: assert property (dq_oe_o |-> !dq_term_o)
      else $error("data termination on while leveling");
   a_fb_value: assert property (dq_oe_o |-> dq_o == 8'h00 ||
      dq_o == 8'hFF) else $error("feedback bits differ");
   a_fb_defined: assert property (dq_oe_o |-> !dq_undef_o)
      else $error("feedback while undefined");
   a_start_pulse: assert property (rd_start_o |=> !rd_start_o)
      else $error("read start not a pulse");
   a_start_burst: assert property (rd_start_o |-> ##[0:1] rd_active_o)
      else $error("no burst after start");
   a_burst_len: assert property ($fell(rd_active_o) |-> (rd_chop_o ?
      (len_q >= 8'h16 && len_q <= 8'h1A) :
      (len_q >= 8'h2E && len_q <= 8'h32))) else $error("bad burst");
   cover property (rd_start_o && rd_chop_o);
   cover property (rd_start_o && !rd_chop_o);
   cover property (dq_oe_o && dq_o == 8'hFF);
endmodule
bind ddrwl_top ddrwl_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_undef_o(dq_undef_o),
   .dq_term_o(dq_term_o), .rd_start_o(rd_start_o),
   .rd_chop_o(rd_chop_o), .rd_active_o(rd_active_o));

// ---- verif/ddrwl_ctl_model.sv ----
`timescale 1ns/1ps
// --------
// Controller model
// --------
module ddrwl_ctl_model
   import ddrwl_pkg::*;
(
   input  wire logic  clk_i,
   output logic       ck_o,
   output ddrwl_cmd_t c_o,
   output logic       strobe_o
);
   realtime t_cmd;
   // Link clock, phase kept off the core clock edges
   initial begin
      ck_o = 1'b0;
      c_o = '{CMD_NOP, 3'h0, 15'h0, 1'b0};
      strobe_o = 1'b0;
      #1.3;
      forever #24 ck_o = ~ck_o;
   end
   // Command held over one ck rise; address inverted when idle
   task automatic send(input logic [3:0] cm, input logic [2:0] ba,
                       input logic [14:0] a);
      @(negedge ck_o);
      @(posedge clk_i);
      c_o <= '{cm, ba, a, c_o.term};
      @(posedge ck_o);
      t_cmd = $realtime;
      @(negedge ck_o);
      @(posedge clk_i);
      c_o <= '{CMD_NOP, ~ba, ~a, c_o.term};
   endtask
   // Termination moves mid-phase for setup margin
   task automatic set_term(input logic v);
      @(negedge ck_o);
      @(posedge clk_i);
      c_o.term <= v;
   endtask
   // One rising strobe edge k core cycles after a ck rise
   task automatic pulse(input int k, output logic lvl);
      @(posedge ck_o);
      repeat (k) @(posedge clk_i);
      strobe_o <= 1'b1;
      lvl = ck_o;
      @(negedge ck_o);
      @(posedge clk_i);
      strobe_o <= 1'b0;
   endtask
endmodule

// ---- verif/ddrwl_top_tb.sv ----
`timescale 1ns/1ps
// --------
// Bench top
// --------
module ddrwl_top_tb;
   import ddrwl_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] rdat, q;
   logic [7:0]  dq;
   logic        ack, ck, stb, oe, und, sterm, dterm, rs, rchop, lvl;
   ddrwl_cmd_t  c;
   int          bad_count = 0;
   int          total_checks = 0;
   int          cyc_cnt = 0;
   int          al, cl, b, k, n;
   realtime     t0;
   always #2 clk_i = ~clk_i;
   ddrwl_ctl_model ctl (.clk_i(clk_i), .ck_o(ck), .c_o(c), .strobe_o(stb));
   ddrwl_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .ck_i(ck),
      .cs_n_i(c.cmd[3]), .ras_n_i(c.cmd[2]), .cas_n_i(c.cmd[1]),
      .we_n_i(c.cmd[0]), .ba_i(c.ba), .addr_i(c.addr),
      .term_ctl_i(c.term), .strobe_i(stb), .dq_o(dq), .dq_oe_o(oe),
      .dq_undef_o(und), .strobe_term_o(sterm), .dq_term_o(dterm),
      .rd_start_o(rs), .rd_chop_o(rchop), .rd_active_o());
   // Expected burst kind and read latency window
   function automatic logic chop_exp(input logic [1:0] bl, input logic a);
      return !(a && bl < 2'h2);
   endfunction
   function automatic logic lat_ok(input real cy);
      return cy >= (al + cl) * 12 + 1 && cy <= (al + cl) * 12 + 7;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Classic cycle held until ack; bounded wait
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      int i;
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 40);
      q = rdat;
      if (i >= 40) chk(ack, 1'b1);
      cyc <= 1'b0;
   endtask
   // Open a random bank, read it, time the data start
   task automatic rd_case(input logic [1:0] bl, input logic a12);
      int i;
      b = $urandom_range(0, 7);
      ctl.send(CMD_MRS, MR_PRIMARY, {13'h0, bl});
      ctl.send(CMD_ACT, b[2:0], 15'($urandom));
      ctl.send(CMD_RD, b[2:0], {2'b00, a12, 12'h000});
      t0 = ctl.t_cmd;
      for (i = 0; i < 1000 && rs !== 1'b1; i++) @(posedge clk_i);
      chk(lat_ok(($realtime - t0) / 4.0), 1'b1);
      chk(rchop, chop_exp(bl, a12));
      ctl.send(CMD_PRE, b[2:0], 15'h0);
      repeat (4) @(posedge ck);
   endtask
   task automatic give_verdict;
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 60000) begin
         bad_count++;
         give_verdict();
      end
   end
   // --------
   // Main sequence
   // --------
   initial begin
      void'($urandom(32'h910cf492));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, REG_LAT, 32'h0, 4'hF);
      chk(q, {24'h0, LAT_CL_RST, LAT_AL_RST});
      wb(1'b1, REG_TRP, 32'hFF, 4'h0);
      wb(1'b0, REG_TRP, 32'h0, 4'hF);
      chk(q, {24'h0, TRP_RST});
      wb(1'b1, 8'h10, 32'hFF, 4'hF);
      wb(1'b0, 8'h10, 32'h0, 4'hF);
      chk(q, 32'h0);
      wb(1'b1, REG_TRP, 32'h3, 4'hF);
      wb(1'b0, REG_TRP, 32'h0, 4'hF);
      chk(q, 32'h3);
      for (k = 0; k < 8; k++) begin
         al = $urandom_range(0, 3);
         cl = $urandom_range(5, 8);
         wb(1'b1, REG_LAT, {24'h0, 4'(cl), 4'(al)}, 4'h1);
         rd_case(k[2:1], k[0]);
      end
      // Auto precharge on one bank, other bank still readable
      ctl.send(CMD_ACT, 3'h2, 15'($urandom));
      ctl.send(CMD_ACT, 3'h3, 15'($urandom));
      ctl.send(CMD_RD, 3'h2, 15'h0400);
      ctl.send(CMD_RD, 3'h3, 15'h1000);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[15:0], 16'h0800);
      ctl.send(CMD_PRE, 3'h0, 15'h0400);
      ctl.send(CMD_WR, 3'h3, 15'h0000);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[15:0], 16'h0001);
      wb(1'b1, REG_STATUS, 32'h1, 4'h1);
      repeat (4) @(posedge ck);
      ctl.send(CMD_ACT, 3'h5, 15'h1234);
      ctl.send(CMD_PRE, 3'h5, 15'h0);
      ctl.send(CMD_ACT, 3'h5, 15'h0001);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[15:0], 16'h0001);
      wb(1'b1, REG_STATUS, 32'h1, 4'h1);
      repeat (4) @(posedge ck);
      ctl.send(CMD_PRE, 3'h5, 15'h0);
      ctl.send(CMD_ACT, 3'h5, 15'h0);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[15:0], 16'h0001);
      wb(1'b1, REG_STATUS, 32'h1, 4'h1);
      repeat (4) @(posedge ck);
      ctl.send(CMD_ACT, 3'h5, 15'h0);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[15:0], 16'h2000);
      ctl.send(CMD_MRS, MR_AUX, 15'h0080);
      chk(und, 1'b1);
      repeat (12) @(posedge ck);
      ctl.set_term(1'b1);
      repeat (2) @(posedge ck);
      chk({sterm, dterm}, 2'b10);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[15:0], 16'h200E);
      for (n = 0; n < 6; n++) begin
         k = $urandom_range(2, 4) + 6 * $urandom_range(0, 1);
         ctl.pulse((n < 2) ? 3 + 6 * n : k, lvl);
         repeat (8) @(posedge clk_i);
         chk({dq, oe, und}, {{8{lvl}}, 2'b10});
      end
      ctl.set_term(1'b0);
      repeat (2) @(posedge ck);
      chk({sterm, dterm}, 2'b00);
      ctl.send(CMD_MRS, MR_AUX, 15'h0000);
      chk({oe, und}, 2'b01);
      repeat (10) @(posedge ck);
      chk(und, 1'b1);
      repeat (3) @(posedge ck);
      repeat (4) @(posedge clk_i);
      chk(und, 1'b0);
      ctl.send(CMD_MRS, MR_AUX, 15'h1080);
      repeat (12) @(posedge ck);
      ctl.pulse(3, lvl);
      repeat (8) @(posedge clk_i);
      chk(oe, 1'b0);
      ctl.send(CMD_MRS, MR_AUX, 15'h1000);
      repeat (14) @(posedge ck);
      wb(1'b0, REG_MODE, 32'h0, 4'hF);
      chk(q, 32'h10000003);
      give_verdict();
   end
endmodule
